// ===== hdl/scsi_status.sv
// Purpose: status and interrupt bits, read one bit at a time on a serial line
// Assumes: all inputs synchronous to CLOCK; datapath events are one-cycle pulses
// Notes: read data and enable are registered, so a read answers one edge late
`timescale 1ns/1ps
`include "scsi_consts.svh"
//
// Contract
// - irq summary is OR of five enabled terms; drives interrupt pin low
// - bit 30 is OR of all seven register load flags
// - modem change flag on filtered DSR, CTS or auto RTS change; cleared by bit 21
// - CTS, DSR shown inverted; auto RTS at 26; raw receive line at 15
// - timer elapsed set on countdown to zero; cleared by write to bit 20
// - timer overrun set when interval expires while elapsed still set
// - tx abort in modes 0,1 only; cleared by bit 22; bit 18 its irq
// - tx buffer empty set on move to shifter or init; zero to bit 25 clears
// - rx buffer full set on character transfer; cleared by write to bit 18
// - modem and timer irq bits are flag AND their enable
// - tx empty irq is empty AND transmit on AND its enable
// - rx irq is OR of full, frame ready, abort, AND rx enable
// - mode 1 rx abort on seven ones after flag; cleared by bit 18
// - modes 5,6 start seen at half bit, first bit one bit later
// - mode 1 frame ready and holding overrun; zero to bit 26 clears
// - modes 5,6 stop error set on bad stop bit, cleared on good one
// - rx overrun on reload while full; cleared on clean load or bit 18
// - parity error follows each transferred character outside mode 1
// - mode 1 zero insert error; cleared when holding read flag reset
// - rx error summary is overrun OR parity OR stop error
// - mode 1 frame flag seen on flag or abort; cleared by bit 18
// - latest character in bits 8..0, right justified, upper bits zero
// - addressed bit driven only while chip enable low; five select lines
// - bits 0..15 show status only while every load flag is clear
module scsi_status #(
  parameter int HALF_BIT_CYCLES = `HALF_BIT_DEF,
  parameter int CNT_W = 16
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE_N,
  input wire logic [4:0] SEL,
  output logic SER_IN_O,
  output logic SER_IN_OE,
  output logic INT_N,
  input wire logic WR_EN,
  input wire logic [4:0] WR_SEL,
  input wire logic WR_DATA,
  input wire logic [2:0] MODE,
  input wire logic [`LOADF_W-1:0] LOAD_FLAGS,
  input wire logic [15:0] ALT_DATA,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic AUTO_RTS,
  input wire logic RX_LINE,
  input wire logic TIMER_ZERO,
  input wire logic TX_NO_DATA,
  input wire logic FILL_EN,
  input wire logic TX_MOVE,
  input wire logic TX_INIT,
  input wire logic RX_INIT,
  input wire logic RX_CHAR,
  input wire logic [`CHAR_W-1:0] RX_DATA,
  input wire logic RX_PAR_BAD,
  input wire logic RX_STOP_BAD,
  input wire logic FRAME_DONE,
  input wire logic HOLD_CHANGE,
  input wire logic FLAG_DET,
  input wire logic SEVEN_ONES,
  input wire logic ZERO_ERR
);

  // mode decode
  wire logic mode1_w = (MODE == `MODE_1);
  wire logic mode01_w = (MODE == `MODE_0) || mode1_w;
  wire logic mode56_w = (MODE == `MODE_5) || (MODE == `MODE_6);

  // output-bit write decode
  wire logic wr_rx_w = WR_EN && (WR_SEL == `OB_RX_EN);
  wire logic wr_te_w = WR_EN && (WR_SEL == `OB_TE_EN);
  wire logic wr_tim_w = WR_EN && (WR_SEL == `OB_TIM_EN);
  wire logic wr_mc_w = WR_EN && (WR_SEL == `OB_MC_EN);
  wire logic wr_ta_w = WR_EN && (WR_SEL == `OB_TA_EN);
  wire logic wr_xon_w = WR_EN && (WR_SEL == `OB_XMT_ON);
  wire logic wr_txb0_w = WR_EN && (WR_SEL == `OB_TXB_LD) && !WR_DATA;
  wire logic wr_hold_w = WR_EN && (WR_SEL == `OB_HOLD_RD);
  wire logic wr_hold0_w = wr_hold_w && !WR_DATA;

  // enable bits held from output-bit writes
  logic xmt_on_r;
  logic rx_en_r;
  logic te_en_r;
  logic tim_en_r;
  logic mc_en_r;
  logic ta_en_r;
  // the holding read level itself is not kept here; only its zero write
  // matters to this block, as the clear of the frame flags below

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      xmt_on_r <= 1'h0;
      rx_en_r <= 1'h0;
      te_en_r <= 1'h0;
      tim_en_r <= 1'h0;
      mc_en_r <= 1'h0;
      ta_en_r <= 1'h0;
    end
    else
    begin
      if (wr_xon_w) xmt_on_r <= WR_DATA;
      if (wr_rx_w) rx_en_r <= WR_DATA;
      if (wr_te_w) te_en_r <= WR_DATA;
      if (wr_tim_w) tim_en_r <= WR_DATA;
      if (wr_mc_w) mc_en_r <= WR_DATA;
      if (wr_ta_w) ta_en_r <= WR_DATA;
    end
  end

  // modem line filter: a level is taken only after two equal samples
  logic cts_d_r;
  logic dsr_d_r;
  logic cts_lvl_r;
  logic dsr_lvl_r;
  logic rts_d_r;
  wire logic cts_take_w = (CTS_N == cts_d_r) && (CTS_N != cts_lvl_r);
  wire logic dsr_take_w = (DSR_N == dsr_d_r) && (DSR_N != dsr_lvl_r);
  wire logic rts_chg_w = (AUTO_RTS != rts_d_r);
  wire logic mchg_set_w = cts_take_w || dsr_take_w || rts_chg_w;

  // pins idle high (inactive) out of reset, so no change is seen at release
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cts_d_r <= 1'h1;
      dsr_d_r <= 1'h1;
      cts_lvl_r <= 1'h1;
      dsr_lvl_r <= 1'h1;
      rts_d_r <= 1'h0;
    end
    else
    begin
      cts_d_r <= CTS_N;
      dsr_d_r <= DSR_N;
      rts_d_r <= AUTO_RTS;
      if (cts_take_w) cts_lvl_r <= CTS_N;
      if (dsr_take_w) dsr_lvl_r <= DSR_N;
    end
  end

  // sticky flags; the set term is tested first so it wins, except that receiver init clears over it
  logic mchg_r;
  logic telp_r;
  logic terr_r;
  logic txab_r;
  logic txbe_r;
  logic rxbf_r;
  logic rx_abort_r;
  logic rx_frame_ready_r;
  logic frame_holding_overrun_r;
  logic stop_r;
  logic rovr_r;
  logic par_r;
  logic zerr_r;
  logic fldt_r;
  logic [`CHAR_W-1:0] rbuf_r;

  wire logic mchg_nxt = mchg_set_w ? 1'h1 : (wr_mc_w ? 1'h0 : mchg_r);
  wire logic telp_nxt = TIMER_ZERO ? 1'h1 : (wr_tim_w ? 1'h0 : telp_r);
  // timer overrun on expiry while elapsed
  wire logic terr_nxt = (TIMER_ZERO && telp_r) ? 1'h1 : (wr_tim_w ? 1'h0 : terr_r);
  // tx abort, modes 0 and 1 only
  wire logic txab_set_w = mode01_w && TX_NO_DATA && !FILL_EN;
  wire logic txab_nxt = txab_set_w ? 1'h1 : (wr_ta_w ? 1'h0 : txab_r);
  wire logic txbe_nxt = (TX_MOVE || TX_INIT) ? 1'h1 : (wr_txb0_w ? 1'h0 : txbe_r);
  wire logic rxbf_nxt = RX_CHAR ? 1'h1 : (wr_rx_w ? 1'h0 : rxbf_r);
  // rx abort after a flag then seven ones
  wire logic rx_abort_set_w = mode1_w && SEVEN_ONES && fldt_r;
  wire logic rx_abort_nxt = rx_abort_set_w ? 1'h1 : (wr_rx_w ? 1'h0 : rx_abort_r);
  wire logic rx_frame_ready_set_w = mode1_w && FRAME_DONE;
  wire logic rx_frame_ready_nxt = rx_frame_ready_set_w ? 1'h1 : (wr_hold0_w ? 1'h0 : rx_frame_ready_r);
  wire logic frame_holding_overrun_set_w = mode1_w && HOLD_CHANGE && rx_frame_ready_r;
  wire logic frame_holding_overrun_nxt = frame_holding_overrun_set_w ? 1'h1 : (wr_hold0_w ? 1'h0 : frame_holding_overrun_r);
  // stop error tracks each character's stop bit in modes 5 and 6
  wire logic stop_nxt = (RX_CHAR && mode56_w) ? RX_STOP_BAD : stop_r;
  // overrun: reload while full; clean load or write clears
  wire logic rovr_set_w = RX_CHAR && rxbf_r;
  wire logic rovr_clr_w = (RX_CHAR && !rxbf_r) || wr_rx_w;
  wire logic rovr_nxt = rovr_set_w ? 1'h1 : (rovr_clr_w ? 1'h0 : rovr_r);
  // parity error follows each transferred character outside mode 1
  wire logic par_nxt = (RX_CHAR && !mode1_w) ? RX_PAR_BAD : par_r;
  // zero insert error, cleared by resetting the holding read flag
  wire logic zerr_set_w = mode1_w && ZERO_ERR;
  wire logic zerr_nxt = zerr_set_w ? 1'h1 : (wr_hold0_w ? 1'h0 : zerr_r);
  // frame flag seen, also on abort
  wire logic fldt_set_w = mode1_w && (FLAG_DET || rx_abort_set_w);
  wire logic fldt_nxt = fldt_set_w ? 1'h1 : (wr_rx_w ? 1'h0 : fldt_r);

  // receiver init clears every receiver flag; transmitter init only sets empty
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mchg_r <= 1'h0;
      telp_r <= 1'h0;
      terr_r <= 1'h0;
      txab_r <= 1'h0;
      txbe_r <= `TXBE_RST;
      rxbf_r <= 1'h0;
      rx_abort_r <= 1'h0;
      rx_frame_ready_r <= 1'h0;
      frame_holding_overrun_r <= 1'h0;
      stop_r <= 1'h0;
      rovr_r <= 1'h0;
      par_r <= 1'h0;
      zerr_r <= 1'h0;
      fldt_r <= 1'h0;
      rbuf_r <= '0;
    end
    else
    begin
      mchg_r <= mchg_nxt;
      telp_r <= telp_nxt;
      terr_r <= terr_nxt;
      txab_r <= txab_nxt;
      txbe_r <= txbe_nxt;
      if (RX_INIT)
      begin
        rxbf_r <= 1'h0;
        rx_abort_r <= 1'h0;
        rx_frame_ready_r <= 1'h0;
        frame_holding_overrun_r <= 1'h0;
        stop_r <= 1'h0;
        rovr_r <= 1'h0;
        par_r <= 1'h0;
        zerr_r <= 1'h0;
        fldt_r <= 1'h0;
      end
      else
      begin
        rxbf_r <= rxbf_nxt;
        rx_abort_r <= rx_abort_nxt;
        rx_frame_ready_r <= rx_frame_ready_nxt;
        frame_holding_overrun_r <= frame_holding_overrun_nxt;
        stop_r <= stop_nxt;
        rovr_r <= rovr_nxt;
        par_r <= par_nxt;
        zerr_r <= zerr_nxt;
        fldt_r <= fldt_nxt;
      end
      // latest character, datapath supplies it right justified
      if (RX_CHAR) rbuf_r <= RX_DATA;
    end
  end

  // start bit detector for the asynchronous modes
  scsi_pkg::scsi_sd_state_t sd_r;
  scsi_pkg::scsi_sd_state_t sd_nxt;
  logic [CNT_W-1:0] sd_cnt_r;
  logic rx_d_r;
  logic sbit_r;
  logic fbit_r;
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] FULL_LAST = CNT_W'(2 * HALF_BIT_CYCLES - 1);
  wire logic rx_fall_w = rx_d_r && !RX_LINE;
  wire logic half_end_w = (sd_cnt_r == HALF_LAST);
  wire logic full_end_w = (sd_cnt_r == FULL_LAST);
  wire logic sd_stop_w = RX_INIT || RX_CHAR || !mode56_w;

  // half-bit check, then first data bit one bit later
  always_comb
  begin
    sd_nxt = sd_r;
    unique case (sd_r)
      scsi_pkg::SD_IDLE: if (mode56_w && rx_fall_w) sd_nxt = scsi_pkg::SD_HALF;
      scsi_pkg::SD_HALF: if (half_end_w)
        sd_nxt = RX_LINE ? scsi_pkg::SD_IDLE : scsi_pkg::SD_WAIT;
      scsi_pkg::SD_WAIT: if (full_end_w) sd_nxt = scsi_pkg::SD_HELD;
      scsi_pkg::SD_HELD: sd_nxt = scsi_pkg::SD_HELD;
      default: sd_nxt = scsi_pkg::SD_IDLE;
    endcase
    if (sd_stop_w) sd_nxt = scsi_pkg::SD_IDLE;
  end

  // counter restarts on every state change, so each leg is timed alone
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sd_r <= scsi_pkg::SD_IDLE;
      sd_cnt_r <= '0;
      rx_d_r <= 1'h1;
      sbit_r <= 1'h0;
      fbit_r <= 1'h0;
    end
    else
    begin
      rx_d_r <= RX_LINE;
      sd_r <= sd_nxt;
      sd_cnt_r <= (sd_nxt != sd_r) ? '0 : sd_cnt_r + 1'b1;
      // flags held until the character ends
      sbit_r <= (sd_nxt == scsi_pkg::SD_WAIT) || (sd_nxt == scsi_pkg::SD_HELD);
      fbit_r <= (sd_nxt == scsi_pkg::SD_HELD);
    end
  end

  // enabled interrupt terms
  // modem and timer irq
  wire logic mirq_w = mchg_r && mc_en_r;
  wire logic tirq_w = telp_r && tim_en_r;
  // tx abort irq, zero outside modes 0 and 1
  wire logic tairq_w = mode01_w && txab_r && ta_en_r;
  wire logic teirq_w = txbe_r && xmt_on_r && te_en_r;
  wire logic rirq_w = (rxbf_r || rx_frame_ready_r || rx_abort_r) && rx_en_r;
  wire logic irq_w = mirq_w || tirq_w || tairq_w || teirq_w || rirq_w;
  wire logic loadf_w = |LOAD_FLAGS;

  // mode-shared bits; 14..12 read zero in unused modes, 10 and 9 show parity and error summary outside mode 1
  wire logic b14_w = mode1_w ? rx_abort_r : (mode56_w && sbit_r);
  wire logic b13_w = mode1_w ? rx_frame_ready_r : (mode56_w && fbit_r);
  wire logic b12_w = mode1_w ? frame_holding_overrun_r : (mode56_w && stop_r);
  // zero error shares bit 10 in mode 1
  wire logic b10_w = mode1_w ? zerr_r : par_r;
  wire logic b9_w = mode1_w ? fldt_r : (rovr_r || par_r || (mode56_w && stop_r));

  // status word in input-bit order
  wire logic [31:0] stat_w;
  assign stat_w[`IB_IRQ] = irq_w;
  assign stat_w[`IB_LOADF] = loadf_w;
  assign stat_w[`IB_MCHG] = mchg_r;
  // CTS and DSR shown inverted, auto RTS and receive line raw
  assign stat_w[`IB_CTS] = !cts_lvl_r;
  assign stat_w[`IB_DSR] = !dsr_lvl_r;
  assign stat_w[`IB_ARTS] = AUTO_RTS;
  assign stat_w[`IB_TELP] = telp_r;
  assign stat_w[`IB_TERR] = terr_r;
  assign stat_w[`IB_TXAB] = mode01_w && txab_r;
  assign stat_w[`IB_TXBE] = txbe_r;
  assign stat_w[`IB_RXBF] = rxbf_r;
  assign stat_w[`IB_MIRQ] = mirq_w;
  assign stat_w[`IB_TIRQ] = tirq_w;
  assign stat_w[`IB_TAIRQ] = tairq_w;
  assign stat_w[`IB_TEIRQ] = teirq_w;
  assign stat_w[`IB_RIRQ] = rirq_w;
  assign stat_w[`IB_RXLN] = RX_LINE;
  assign stat_w[`IB_B14] = b14_w;
  assign stat_w[`IB_B13] = b13_w;
  assign stat_w[`IB_B12] = b12_w;
  assign stat_w[`IB_ROVR] = rovr_r;
  assign stat_w[`IB_B10] = b10_w;
  assign stat_w[`IB_B9] = b9_w;
  assign stat_w[`IB_CHAR_HI:0] = rbuf_r;

  // low half shows register contents while any load flag is set
  wire logic [`IB_LOW_HI:0] low_w = loadf_w ? ALT_DATA : stat_w[`IB_LOW_HI:0];
  wire logic [31:0] rd_w = {stat_w[31:`IB_LOW_HI+1], low_w};

  // read path is pure selection, touching no flag
  wire logic sel_bit_w = rd_w[SEL];

  // registered pin outputs; line released while chip enable is high
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SER_IN_O <= 1'h0;
      SER_IN_OE <= 1'h0;
      INT_N <= 1'h1;
    end
    else
    begin
      // drive only while chip enable low
      SER_IN_OE <= !CE_N;
      SER_IN_O <= !CE_N && sel_bit_w;
      INT_N <= !irq_w;
    end
  end

endmodule : scsi_status

// ===== pkg/scsi_consts.svh
// Purpose: named constants of the status bit block
// Assumes: bit-addressed serial status reads, output-bit writes
// Notes: definitions only
`ifndef SCSI_CONSTS_SVH
`define SCSI_CONSTS_SVH
// input select bit positions
`define IB_IRQ 31
`define IB_LOADF 30
`define IB_MCHG 29
`define IB_CTS 28
`define IB_DSR 27
`define IB_ARTS 26
`define IB_TELP 25
`define IB_TERR 24
`define IB_TXAB 23
`define IB_TXBE 22
`define IB_RXBF 21
`define IB_MIRQ 20
`define IB_TIRQ 19
`define IB_TAIRQ 18
`define IB_TEIRQ 17
`define IB_RIRQ 16
`define IB_RXLN 15
`define IB_B14 14
`define IB_B13 13
`define IB_B12 12
`define IB_ROVR 11
`define IB_B10 10
`define IB_B9 9
`define IB_CHAR_HI 8
`define IB_LOW_HI 15
// output select bit positions that this block decodes
`define OB_XMT_ON 5'h10
`define OB_RX_EN 5'h12
`define OB_TE_EN 5'h13
`define OB_TIM_EN 5'h14
`define OB_MC_EN 5'h15
`define OB_TA_EN 5'h16
`define OB_TXB_LD 5'h19
`define OB_HOLD_RD 5'h1A
// operating modes
`define MODE_0 3'h0
`define MODE_1 3'h1
`define MODE_2 3'h2
`define MODE_3 3'h3
`define MODE_5 3'h5
`define MODE_6 3'h6
// widths and reset values
`define CHAR_W 9
`define LOADF_W 7
`define TXBE_RST 1'h1
`define HALF_BIT_DEF 16
`endif

// ===== pkg/scsi_pkg.sv
// Purpose: types of the status bit block
// Assumes: constants come from scsi_consts.svh
// Notes: one-hot start detector states
package scsi_pkg;
  typedef logic [2:0] scsi_mode_t;
  typedef enum logic [3:0] {
    SD_IDLE = 4'h1,
    SD_HALF = 4'h2,
    SD_WAIT = 4'h4,
    SD_HELD = 4'h8
  } scsi_sd_state_t;
endpackage : scsi_pkg

// ===== sim/scsi_status_properties.sv
// Purpose: concurrent checks on the status bit block ports
// Assumes: one clock domain, async active-low reset
// Notes: small shadow flags model only what the checks need
`timescale 1ns/1ps
module scsi_status_chk (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE_N,
  input wire logic [4:0] SEL,
  input wire logic SER_IN_O,
  input wire logic SER_IN_OE,
  input wire logic INT_N,
  input wire logic WR_EN,
  input wire logic [4:0] WR_SEL,
  input wire logic [6:0] LOAD_FLAGS,
  input wire logic [15:0] ALT_DATA,
  input wire logic CTS_N,
  input wire logic RX_LINE,
  input wire logic RX_INIT,
  input wire logic RX_CHAR,
  input wire logic [8:0] RX_DATA
);
  logic rbf_r;
  logic got_r;
  logic bit_r;
  logic alt_r;
  logic [8:0] chr_r;
  wire clr_full;
  // any write to the receive enable bit clears the full flag
  assign clr_full = WR_EN && WR_SEL == 5'h12;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  // shadow of full flag and character-received flag; receiver clear wins over a set
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rbf_r <= 1'h0;
      got_r <= 1'h0;
    end
    else
    begin
      rbf_r <= !RX_INIT && (RX_CHAR || (rbf_r && !clr_full));
      got_r <= !RX_INIT && (RX_CHAR || got_r);
    end
  end
  // expected read bits, taken at the sampling edge like the design
  always_ff @(posedge CLOCK)
  begin
    if (RX_CHAR)
      chr_r <= RX_DATA;
    bit_r <= chr_r[SEL[3:0]];
    alt_r <= ALT_DATA[SEL[3:0]];
  end
  chk_oe_when_selected: assert property (!CE_N |=> SER_IN_OE)
    else $error("serial line not driven while selected");
  chk_line_released: assert property (CE_N |=> !SER_IN_OE && !SER_IN_O)
    else $error("serial line driven while deselected");
  chk_irq_pin_match: assert property ((!CE_N && SEL == 5'h1F) |=> SER_IN_O == !INT_N)
    else $error("interrupt pin disagrees with summary bit");
  chk_load_pending: assert property ((!CE_N && SEL == 5'h1E) |=>
    SER_IN_O == ($past(LOAD_FLAGS) != 7'h00))
    else $error("load pending bit wrong");
  chk_cts_shown: assert property ((!CE_N && SEL == 5'h1C && !CTS_N && !$past(CTS_N)
    && !$past(CTS_N, 2) && $past(RST_N, 2)) |=> SER_IN_O)
    else $error("clear to send not shown inverted");
  chk_raw_rx_line: assert property ((!CE_N && SEL == 5'h0F && LOAD_FLAGS == 7'h00) |=>
    SER_IN_O == $past(RX_LINE))
    else $error("receive line level wrong");
  chk_rx_full_flag: assert property ((!CE_N && SEL == 5'h15) |=> SER_IN_O == $past(rbf_r))
    else $error("buffer full flag wrong");
  chk_char_field: assert property ((!CE_N && SEL < 5'h09 && LOAD_FLAGS == 7'h00 && got_r)
    |=> SER_IN_O == bit_r)
    else $error("received character bit wrong");
  chk_alt_view: assert property ((!CE_N && !SEL[4] && LOAD_FLAGS != 7'h00) |=>
    SER_IN_O == alt_r)
    else $error("register view bit wrong");
  cover property (RX_CHAR);
  cover property (!INT_N);
  cover property (!CE_N && LOAD_FLAGS != 7'h00);
endmodule : scsi_status_chk

bind scsi_status scsi_status_chk chk_u (.CLOCK(CLOCK), .RST_N(RST_N), .CE_N(CE_N), .SEL(SEL),
  .SER_IN_O(SER_IN_O), .SER_IN_OE(SER_IN_OE), .INT_N(INT_N), .WR_EN(WR_EN), .WR_SEL(WR_SEL),
  .LOAD_FLAGS(LOAD_FLAGS), .ALT_DATA(ALT_DATA), .CTS_N(CTS_N), .RX_LINE(RX_LINE),
  .RX_INIT(RX_INIT), .RX_CHAR(RX_CHAR), .RX_DATA(RX_DATA));

// ===== sim/scsi_host.sv
// Purpose: host side of the serial status line
// Assumes: one bit per read, answer one edge after the sampled select
// Notes: an undriven line shows a toggling pattern, never the last bit
`timescale 1ns/1ps
module scsi_host (
  input wire logic clk,
  input wire logic so,
  input wire logic soe,
  output logic ce_n,
  output logic [4:0] sel,
  output logic bit_o,
  output logic vld
);
  logic last;
  wire line;
  // released line: inverse of the last sampled level
  assign line = soe ? so : ~last;
  initial
  begin
    ce_n = 1'h1;
    sel = 5'h00;
    bit_o = 1'h0;
    vld = 1'h0;
    last = 1'h0;
  end
  // follow the line so a floating read changes every cycle
  always @(posedge clk)
    last <= line;
  // select held low through the answer edge
  task automatic rd(input logic [4:0] s);
    @(posedge clk);
    #1 ce_n = 1'h0;
    sel = s;
    @(posedge clk);
    @(posedge clk);
    bit_o = line;
    #1 vld = 1'h1;
    ce_n = 1'h1;
    sel = ~s;
    @(posedge clk);
    #1 vld = 1'h0;
  endtask : rd
endmodule : scsi_host

// ===== sim/scsi_status_tb.sv
// Purpose: self-checking bench of the status bit block
// Assumes: 40 MHz clock, host model performs the serial reads
// Notes: the driver queues expected bits, the monitor pops them
`timescale 1ns/1ps
`define CMP(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %b got %b", n, e, s); end end
module scsi_status_tb;
  logic CLOCK, RST_N, WR_EN, WR_DATA, CTS_N, DSR_N, AUTO_RTS, RX_LINE, TIMER_ZERO;
  logic TX_NO_DATA, FILL_EN, TX_MOVE, TX_INIT, RX_INIT, RX_CHAR, RX_PAR_BAD, RX_STOP_BAD;
  logic FRAME_DONE, HOLD_CHANGE, FLAG_DET, SEVEN_ONES, ZERO_ERR;
  logic [4:0] WR_SEL;
  logic [2:0] MODE;
  logic [6:0] LOAD_FLAGS;
  logic [15:0] ALT_DATA;
  logic [8:0] RX_DATA;
  wire CE_N, SER_IN_O, SER_IN_OE, INT_N, rd_bit, rd_vld;
  wire [4:0] SEL;
  logic [5:0] note_q[$];
  logic [5:0] note;
  logic [31:0] lf;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  int error_cnt = 0;
  int checked = 0;
  int i;
  scsi_status #(.HALF_BIT_CYCLES(4)) dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .CE_N(CE_N),
    .SEL(SEL), .SER_IN_O(SER_IN_O), .SER_IN_OE(SER_IN_OE), .INT_N(INT_N), .WR_EN(WR_EN),
    .WR_SEL(WR_SEL), .WR_DATA(WR_DATA), .MODE(MODE), .LOAD_FLAGS(LOAD_FLAGS),
    .ALT_DATA(ALT_DATA), .CTS_N(CTS_N), .DSR_N(DSR_N), .AUTO_RTS(AUTO_RTS),
    .RX_LINE(RX_LINE), .TIMER_ZERO(TIMER_ZERO), .TX_NO_DATA(TX_NO_DATA), .FILL_EN(FILL_EN),
    .TX_MOVE(TX_MOVE), .TX_INIT(TX_INIT), .RX_INIT(RX_INIT), .RX_CHAR(RX_CHAR),
    .RX_DATA(RX_DATA), .RX_PAR_BAD(RX_PAR_BAD), .RX_STOP_BAD(RX_STOP_BAD),
    .FRAME_DONE(FRAME_DONE), .HOLD_CHANGE(HOLD_CHANGE), .FLAG_DET(FLAG_DET),
    .SEVEN_ONES(SEVEN_ONES), .ZERO_ERR(ZERO_ERR));
  scsi_host host_u (.clk(CLOCK), .so(SER_IN_O), .soe(SER_IN_OE), .ce_n(CE_N), .sel(SEL),
    .bit_o(rd_bit), .vld(rd_vld));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  task automatic pulse(ref logic s);
    @(posedge CLOCK);
    #1 s = 1'h1;
    @(posedge CLOCK);
    #1 s = 1'h0;
  endtask : pulse
  task automatic wr(input logic [4:0] a, input logic d);
    @(posedge CLOCK);
    #1 WR_EN = 1'h1;
    WR_SEL = a;
    WR_DATA = d;
    @(posedge CLOCK);
    #1 WR_EN = 1'h0;
  endtask : wr
  // queue the expected bit, then let the host read it
  task automatic chk(input logic [4:0] a, input logic e);
    note_q.push_back({a, e});
    host_u.rd(a);
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial
  begin
    CLOCK = 1'h0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  // monitor: each returned bit meets the oldest note
  always @(posedge CLOCK)
  begin
    if (rd_vld === 1'h1)
    begin
      note = note_q.pop_front();
      `CMP($sformatf("bit %0d", note[5:1]), note[0], rd_bit)
    end
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge CLOCK);
    error_cnt++;
    conclude();
  end
  initial
  begin
    {WR_EN, WR_DATA, AUTO_RTS, TIMER_ZERO, TX_NO_DATA, FILL_EN, TX_MOVE, TX_INIT} = '0;
    {RX_INIT, RX_CHAR, RX_PAR_BAD, RX_STOP_BAD, FRAME_DONE, HOLD_CHANGE, FLAG_DET} = '0;
    {SEVEN_ONES, ZERO_ERR, WR_SEL, MODE, LOAD_FLAGS, ALT_DATA, RX_DATA} = '0;
    {CTS_N, DSR_N, RX_LINE} = 3'h7;
    lf = 32'hE085BF4C;
    RST_N = 1'h0;
    repeat (20) @(posedge CLOCK);
    #1 RST_N = 1'h1;
    chk(5'h16, 1'h1);
    chk(5'h1F, 1'h0);
    // receive path: character, parity, overrun, irq
    wr(5'h12, 1'h1);
    lf = nx(lf);
    RX_DATA = lf[8:0];
    RX_PAR_BAD = 1'h1;
    pulse(RX_CHAR);
    for (i = 0; i < 9; i++)
      chk(5'(i), lf[i]);
    chk(5'h15, 1'h1);
    chk(5'h10, 1'h1);
    chk(5'h1F, 1'h1);
    chk(5'h0A, 1'h1);
    chk(5'h0B, 1'h0);
    RX_PAR_BAD = 1'h0;
    pulse(RX_CHAR);
    chk(5'h0B, 1'h1);
    chk(5'h0A, 1'h0);
    chk(5'h09, 1'h1);
    wr(5'h12, 1'h1);
    chk(5'h15, 1'h0);
    chk(5'h0B, 1'h0);
    chk(5'h09, 1'h0);
    // transmit buffer empty and its irq
    wr(5'h10, 1'h1);
    wr(5'h13, 1'h1);
    chk(5'h11, 1'h1);
    wr(5'h19, 1'h0);
    chk(5'h16, 1'h0);
    chk(5'h11, 1'h0);
    pulse(TX_MOVE);
    chk(5'h16, 1'h1);
    wr(5'h19, 1'h0);
    pulse(TX_INIT);
    chk(5'h16, 1'h1);
    // abort only exists in the two lowest modes
    for (i = 0; i < 6; i++)
    begin
      MODE = modes[i];
      wr(5'h16, 1'h1);
      pulse(TX_NO_DATA);
      chk(5'h17, MODE < 3'h2);
      chk(5'h12, MODE < 3'h2);
    end
    MODE = 3'h0;
    FILL_EN = 1'h1;
    wr(5'h16, 1'h1);
    pulse(TX_NO_DATA);
    chk(5'h17, 1'h0);
    FILL_EN = 1'h0;
    // interval timer flags
    pulse(TIMER_ZERO);
    chk(5'h19, 1'h1);
    chk(5'h13, 1'h0);
    pulse(TIMER_ZERO);
    chk(5'h18, 1'h1);
    wr(5'h14, 1'h1);
    chk(5'h19, 1'h0);
    chk(5'h18, 1'h0);
    pulse(TIMER_ZERO);
    chk(5'h13, 1'h1);
    // modem lines: a one-cycle glitch must not count
    CTS_N = 1'h0;
    repeat (3) @(posedge CLOCK);
    chk(5'h1C, 1'h1);
    chk(5'h1B, 1'h0);
    chk(5'h1D, 1'h1);
    wr(5'h15, 1'h1);
    @(posedge CLOCK);
    #1 DSR_N = 1'h0;
    @(posedge CLOCK);
    #1 DSR_N = 1'h1;
    chk(5'h1D, 1'h0);
    AUTO_RTS = 1'h1;
    chk(5'h1A, 1'h1);
    chk(5'h14, 1'h1);
    // register view replaces low status bits
    for (i = 0; i < 7; i++)
    begin
      lf = nx(lf);
      ALT_DATA = lf[15:0];
      LOAD_FLAGS = 7'h01 << i;
      chk(5'h1E, 1'h1);
      chk(5'(i), lf[i]);
    end
    LOAD_FLAGS = 7'h00;
    chk(5'h1E, 1'h0);
    // start detect and stop bit in mode 5
    MODE = 3'h5;
    @(posedge CLOCK);
    #1 RX_LINE = 1'h0;
    repeat (7) @(posedge CLOCK);
    chk(5'h0E, 1'h1);
    chk(5'h0F, 1'h0);
    repeat (8) @(posedge CLOCK);
    chk(5'h0D, 1'h1);
    RX_LINE = 1'h1;
    RX_STOP_BAD = 1'h1;
    pulse(RX_CHAR);
    chk(5'h0E, 1'h0);
    chk(5'h0C, 1'h1);
    RX_STOP_BAD = 1'h0;
    pulse(RX_CHAR);
    chk(5'h0C, 1'h0);
    chk(5'h0B, 1'h1);
    // receiver clear drops the loaded and overrun flags
    pulse(RX_INIT);
    chk(5'h15, 1'h0);
    chk(5'h0B, 1'h0);
    // frame events in mode 1
    MODE = 3'h1;
    wr(5'h12, 1'h1);
    pulse(FLAG_DET);
    chk(5'h09, 1'h1);
    pulse(SEVEN_ONES);
    chk(5'h0E, 1'h1);
    chk(5'h10, 1'h1);
    pulse(FRAME_DONE);
    chk(5'h0D, 1'h1);
    pulse(HOLD_CHANGE);
    chk(5'h0C, 1'h1);
    pulse(ZERO_ERR);
    chk(5'h0A, 1'h1);
    wr(5'h1A, 1'h0);
    chk(5'h0C, 1'h0);
    chk(5'h0A, 1'h0);
    wr(5'h12, 1'h0);
    chk(5'h0E, 1'h0);
    chk(5'h09, 1'h0);
    chk(5'h10, 1'h0);
    conclude();
  end
endmodule : scsi_status_tb
